// *** tsense_defs.svh ***
// Register addresses, field positions, reset values and format limits.
// Assumes inclusion by bare name from the sensor design files.
`ifndef TSENSE_DEFS_SVH
`define TSENSE_DEFS_SVH
// Read addresses of the high and low result bytes.
`define A_INT_HI 8'h00
`define A_INT_LO 8'h23
`define A_R1_HI 8'h01
`define A_R1_LO 8'h10
`define A_R2_HI 8'hf8
`define A_R2_LO 8'hf9
`define A_R1X_HI 8'hfa
`define A_R1X_LO 8'hfb
`define A_R2X_HI 8'hfc
`define A_R2X_LO 8'hfd
// Status, configuration, one-shot and identification addresses.
`define A_STATUS 8'h02
`define A_CFG_RD 8'h03
`define A_CFG_WR 8'h09
`define A_ONESHOT 8'h0f
`define A_MAKER 8'hfe
`define A_REV 8'hff
// Production test addresses, outside the functional map.
`define A_TST0 8'h11
`define A_TST1 8'h16
`define A_TST2 8'h4a
`define A_TST3 8'h60
`define A_TST4 8'h61
`define A_TST5 8'h62
`define A_TST6 8'h79
`define A_TST7 8'h7a
// Reset values and configuration fields.
`define CFG_RESET 8'h47
`define CFG_STBY_BIT 6
`define CFG_RATE_MSB 2
`define ZERO_BYTE 8'h00
`define ST_BUSY_BIT 7
// Raw results are signed twelve-bit counts of eighths of a degree.
`define RAW_MIN 12'he01
`define LEG_MAX 12'h3ff
`define EXT_MAX 12'h5ff
`define EXT_OFFSET 12'h200
`define FAULT_CODE 16'h8000
`define FRAC_PAD 5'h00
`endif

// *** tsense_pkg.sv ***
// Types shared by the sensor register map modules.
// Assumes nothing beyond a SystemVerilog compiler.
package tsense_pkg;
    // Conversion sequencer states.
    typedef enum logic [0:0] {
        ST_IDLE = 1'b0,
        ST_CONV = 1'b1
    } conv_state_t;
    // Zone number as given by the converter front end.
    typedef logic [1:0] zone_t;
endpackage : tsense_pkg

// *** result_pair_if.sv ***
// Carrier between the register map and one result pair holder.
// Assumes both ends share the register map clock.
`timescale 1ns/1ps
interface result_pair_if;
    logic load;          // New conversion word is available.
    logic [15:0] word;   // Formatted word to store.
    logic hi_rd;         // Host reads this pair's high byte.
    logic [15:0] fresh;  // Most recent conversion word.
    logic [15:0] view;   // Word the host reads back.
    modport holder (input load, word, hi_rd, output fresh, view);
    modport user (output load, word, hi_rd, input fresh, view);
endinterface : result_pair_if

// *** temp_format.sv ***
// Turns one raw reading into the legacy or extended register word.
// Assumes raw counts are signed eighths of a degree.
`timescale 1ns/1ps
`include "tsense_defs.svh"
module temp_format (
    // Raw reading.
    input wire logic [11:0] raw_i,
    input wire logic fault_i,
    input wire logic ext_i,
    // Formatted word.
    output logic [15:0] word_o
);
    logic signed [11:0] clamp_hi; // Upper limit for this format.
    logic signed [11:0] clamped;  // Saturated reading.
    logic signed [11:0] shifted;  // Reading after the format offset.

    // Saturate, offset and left-align the result.
    always_comb
    begin
        clamp_hi = ext_i ? `EXT_MAX : `LEG_MAX;
        if ($signed(raw_i) < $signed(`RAW_MIN))
        begin
            clamped = `RAW_MIN;
        end
        else if ($signed(raw_i) > clamp_hi)
        begin
            clamped = clamp_hi;
        end
        else
        begin
            clamped = raw_i;
        end
        shifted = ext_i ? clamped - `EXT_OFFSET : clamped;
        if (fault_i)
        begin
            word_o = `FAULT_CODE;
        end
        else
        begin
            word_o = {shifted[10:0], `FRAC_PAD};
        end
    end
endmodule : temp_format

// *** result_pair.sv ***
// Holds one result pair: the latest word and the word the host reads.
// Assumes one clock and an asynchronous active-low reset.
`timescale 1ns/1ps
`include "tsense_defs.svh"
module result_pair (
    // Clock and reset.
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Pair traffic.
    result_pair_if.holder pr
);
    logic [15:0] fresh_q; // Latest conversion word.
    logic [15:0] view_q;  // Latched word for host reads.

    // Each conversion refreshes the latest word.
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            fresh_q <= {`ZERO_BYTE, `ZERO_BYTE};
        end
        else if (pr.load)
        begin
            fresh_q <= pr.word;
        end
    end

    // A high-byte read freezes the latest word for the following low read.
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            view_q <= {`ZERO_BYTE, `ZERO_BYTE};
        end
        else if (pr.hi_rd)
        begin
            view_q <= fresh_q;
        end
    end

    assign pr.fresh = fresh_q;
    assign pr.view = view_q;

    // The frozen pair takes the latest word on a high read, else holds.
    a_pair_latch: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        pr.hi_rd |=> view_q == $past(fresh_q))
        else $error("pair not latched on high byte read");
    a_pair_hold: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        !pr.hi_rd |=> $stable(view_q))
        else $error("pair changed without a high byte read");
endmodule : result_pair

// *** tsense_regmap.sv ***
// Functional notes
// - Reset loads every register default.
// - Undefined address reads return zero.
// - Undefined address writes change nothing.
// - High read latches latest pair.
// - Internal result at 00h and 23h.
// - Remote one legacy at 01h, 10h.
// - Remote two legacy at F8h, F9h.
// - Extended results at FAh to FDh.
// - Read-only status at 02h, reset zero.
// - Test addresses are outside the map.
// - High byte: sign, whole degrees.
// - Low byte: three fraction bits, rest zero.
// - Legacy is two's complement, eighths.
// - Legacy saturates at -63.875 and 127.875.
// - Extended equals legacy minus 64.
// - Extended saturates at -63.875 and 191.875.
// - Both formats updated in one step.
// - Diode fault reads as 8000h.
// - Status bits 0,1 flag diode faults.
// - Status bit 7 shows conversion busy.
// - One-shot in standby converts once.
//
// Register map of a three-zone temperature sensor behind a byte port.
// Assumes a serial-bus slave delivers one-cycle read and write strobes
// and a converter front end that reports each zone's result.
`timescale 1ns/1ps
`include "tsense_defs.svh"
module tsense_regmap
    import tsense_pkg::*;
#(
    parameter logic [7:0] MAKER_CODE = 8'ha5, // Arbitrary identification value.
    parameter logic [7:0] REV_CODE = 8'h0b    // Arbitrary identification value.
) (
    // Clock and reset.
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Register byte port from the serial-bus slave.
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [7:0] rd_data_o,
    output logic rd_valid_o,
    // Converter front end.
    input wire logic adc_done_i,
    input wire logic [1:0] adc_zone_i,
    input wire logic [11:0] adc_raw_i,
    input wire logic adc_fault_i,
    output logic conv_start_o,
    output logic [2:0] conv_rate_o
);
    localparam int NPAIR = 5; // Internal, remote legacy two, remote extended two.

    // Per-pair addresses, source zone and format.
    localparam logic [7:0] HI_ADDR [NPAIR] =
        '{`A_INT_HI, `A_R1_HI, `A_R2_HI, `A_R1X_HI, `A_R2X_HI};
    localparam logic [7:0] LO_ADDR [NPAIR] =
        '{`A_INT_LO, `A_R1_LO, `A_R2_LO, `A_R1X_LO, `A_R2X_LO};
    localparam zone_t PAIR_ZONE [NPAIR] = '{2'h0, 2'h1, 2'h2, 2'h1, 2'h2};
    localparam logic PAIR_EXT [NPAIR] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1};
    localparam zone_t LAST_ZONE = 2'h2; // Zone that closes a conversion cycle.

    conv_state_t state_q;      // Conversion sequencer state.
    logic [7:0] cfg_q;         // Configuration register.
    logic oneshot_q;           // One-shot request pending.
    logic [1:0] fault_q;       // Remote diode fault flags.
    logic [7:0] rd_data_q;     // Read data register.
    logic rd_valid_q;          // Read answer strobe.
    logic [7:0] status;        // Status register view.
    logic standby;             // Standby mode selected.
    logic cycle_end;           // Last zone of a cycle reported.
    logic test_addr;           // Address is a production test location.
    logic [7:0] rd_mux;        // Read data before the register.
    logic [15:0] fresh_w [NPAIR]; // Latest word of each pair, for the read mux.
    logic [15:0] view_w [NPAIR];  // Frozen word of each pair, for the read mux.

    result_pair_if pif [NPAIR] ();

    // Result pairs: one formatter and one holder each.
    for (genvar p = 0; p < NPAIR; p++)
    begin : g_pair
        logic hi_hit; // Host reads this pair's high byte.
        assign hi_hit = reg_rd_i && (reg_addr_i == HI_ADDR[p]);
        assign pif[p].hi_rd = hi_hit;
        // Both formats of a zone load on the same done strobe.
        assign pif[p].load = adc_done_i && (adc_zone_i == PAIR_ZONE[p]);
        temp_format u_fmt (
            .raw_i(adc_raw_i),
            .fault_i(adc_fault_i && (PAIR_ZONE[p] != 2'h0)),
            .ext_i(PAIR_EXT[p]),
            .word_o(pif[p].word)
        );
        result_pair u_pair (
            .clk_i(clk_i),
            .rst_n_i(rst_n_i),
            .pr(pif[p])
        );
        assign fresh_w[p] = pif[p].fresh;
        assign view_w[p] = pif[p].view;
    end

    assign standby = cfg_q[`CFG_STBY_BIT];
    assign cycle_end = adc_done_i && (adc_zone_i == LAST_ZONE);
    assign status = {state_q == ST_CONV, 5'h00, fault_q};
    assign conv_rate_o = cfg_q[`CFG_RATE_MSB:0];

    // Production test addresses decode to nothing.
    always_comb
    begin
        case (reg_addr_i)
            `A_TST0, `A_TST1, `A_TST2, `A_TST3,
            `A_TST4, `A_TST5, `A_TST6, `A_TST7: test_addr = 1'b1;
            default: test_addr = 1'b0;
        endcase
    end

    // Read multiplexer; high bytes come from the latest word, low from the frozen one.
    always_comb
    begin
        rd_mux = `ZERO_BYTE;
        if (!test_addr)
        begin
            case (reg_addr_i)
                `A_STATUS: rd_mux = status;
                `A_CFG_RD: rd_mux = cfg_q;
                `A_MAKER: rd_mux = MAKER_CODE;
                `A_REV: rd_mux = REV_CODE;
                default: rd_mux = `ZERO_BYTE;
            endcase
            for (int i = 0; i < NPAIR; i++)
            begin
                if (reg_addr_i == HI_ADDR[i])
                begin
                    rd_mux = fresh_w[i][15:8];
                end
                if (reg_addr_i == LO_ADDR[i])
                begin
                    // A low byte read first returns the older frozen word.
                    rd_mux = view_w[i][7:0];
                end
            end
        end
    end

    // Read answer is registered one cycle after the strobe.
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            rd_data_q <= `ZERO_BYTE;
            rd_valid_q <= 1'b0;
        end
        else
        begin
            rd_valid_q <= reg_rd_i;
            if (reg_rd_i)
            begin
                rd_data_q <= rd_mux;
            end
        end
    end

    assign rd_data_o = rd_data_q;
    assign rd_valid_o = rd_valid_q;

    // Configuration register; only the defined fields are kept.
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            cfg_q <= `CFG_RESET;
        end
        else if (reg_wr_i && reg_addr_i == `A_CFG_WR)
        begin
            cfg_q <= reg_wdata_i & `CFG_RESET;
        end
    end

    // One-shot request: taken only in standby, cleared when the cycle ends.
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            oneshot_q <= 1'b0;
        end
        else if (reg_wr_i && reg_addr_i == `A_ONESHOT && standby)
        begin
            oneshot_q <= 1'b1;
        end
        else if (state_q == ST_CONV && cycle_end)
        begin
            oneshot_q <= 1'b0;
        end
    end

    // Sequencer: run mode converts back to back, standby waits for a one-shot.
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            state_q <= ST_IDLE;
        end
        else
        begin
            case (state_q)
                ST_IDLE:
                begin
                    if (!standby || oneshot_q)
                    begin
                        state_q <= ST_CONV;
                    end
                end
                ST_CONV:
                begin
                    if (cycle_end)
                    begin
                        state_q <= ST_IDLE;
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    assign conv_start_o = (state_q == ST_IDLE) && (!standby || oneshot_q);

    // Diode fault flags follow the latest result of each remote zone.
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            fault_q <= 2'b00;
        end
        else if (adc_done_i && adc_zone_i != 2'h0)
        begin
            fault_q[adc_zone_i[1]] <= adc_fault_i;
        end
    end

    // Reads of production test addresses answer zero.
    // Test locations must look like empty space to the host.
    a_undef_read_zero: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        reg_rd_i
        && test_addr
        |=> rd_valid_o
        && rd_data_o == `ZERO_BYTE)
        else $error("undefined address did not read zero");

    // Writes elsewhere leave configuration alone.
    // A stray write must never switch the device out of standby.
    a_undef_write_none: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        reg_wr_i
        && reg_addr_i != `A_CFG_WR
        |=> $stable(cfg_q))
        else $error("configuration changed by another address");

    // Configuration write appears on the read address.
    // The host port leaves one idle cycle between two strobes.
    a_cfg_round_trip: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        reg_wr_i && reg_addr_i == `A_CFG_WR
        ##1 !reg_wr_i
        ##1 reg_rd_i && reg_addr_i == `A_CFG_RD
        |=> rd_data_o == ($past(reg_wdata_i, 3) & `CFG_RESET))
        else $error("configuration read back wrong");

    // Busy bit tracks the sequencer.
    // The read sees the state at its own strobe edge.
    a_status_busy: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        reg_rd_i
        && reg_addr_i == `A_STATUS
        |=> rd_data_o[`ST_BUSY_BIT] == $past(state_q == ST_CONV))
        else $error("status busy bit wrong");

    // A fault on remote one sets its status bit and the fault code.
    a_fault_flag: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        adc_done_i && adc_fault_i
        && adc_zone_i == 2'h1
        |=> fault_q[0]
        && pif[1].fresh == `FAULT_CODE
        && pif[3].fresh == `FAULT_CODE)
        else $error("remote one fault not reported");

    // A fault on remote two sets its status bit and the fault code.
    a_fault_two: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        adc_done_i && adc_fault_i
        && adc_zone_i == 2'h2
        |=> fault_q[1]
        && pif[2].fresh == `FAULT_CODE
        && pif[4].fresh == `FAULT_CODE)
        else $error("remote two fault not reported");

    // A clean result of remote one clears its fault flag.
    a_fault_clear: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        adc_done_i && !adc_fault_i
        && adc_zone_i == 2'h1
        |=> !fault_q[0])
        else $error("remote one fault flag stuck");

    // Extended word sits 64 degrees below the legacy word inside the common range.
    // Both words load on the same edge, so they are compared side by side.
    a_ext_offset: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        adc_done_i && !adc_fault_i
        && adc_zone_i == 2'h2
        && $signed(adc_raw_i) >= $signed(`RAW_MIN)
        && $signed(adc_raw_i) <= $signed(`LEG_MAX)
        |=> pif[4].fresh == 16'(pif[2].fresh - 16'({`EXT_OFFSET, `FRAC_PAD})))
        else $error("extended word offset wrong");

    // One-shot in standby starts exactly one cycle of conversion.
    a_oneshot_start: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        standby && state_q == ST_IDLE && !oneshot_q
        && reg_wr_i && reg_addr_i == `A_ONESHOT
        |=> oneshot_q ##0 conv_start_o
        ##1 state_q == ST_CONV)
        else $error("one-shot did not start a conversion");

    // The last zone of a cycle drops the busy state.
    a_cycle_end: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        state_q == ST_CONV && cycle_end
        |=> state_q == ST_IDLE)
        else $error("conversion cycle did not end");

    // Identification bytes are fixed.
    a_id_read: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        reg_rd_i && reg_addr_i == `A_REV
        |=> rd_data_o == REV_CODE)
        else $error("revision code read wrong");

    // The maker byte is fixed as well.
    a_maker_read: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        reg_rd_i && reg_addr_i == `A_MAKER
        |=> rd_data_o == MAKER_CODE)
        else $error("maker code read wrong");

    // Low byte fraction padding stays zero.
    a_low_pad: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        reg_rd_i && reg_addr_i == `A_R1_LO
        |=> rd_data_o[4:0] == `FRAC_PAD)
        else $error("low byte padding not zero");
endmodule : tsense_regmap

// *** tsense_host_model.sv ***
// Host-side model of the serial-bus slave that strobes the register byte port.
// Assumes the sensor samples strobes on the rising edge of the shared clock.
`timescale 1ns/1ps
module tsense_host_model (
    // Clock.
    input wire logic clk_i,
    // Register byte port towards the sensor.
    output logic [7:0] reg_addr_o,
    output logic [7:0] reg_wdata_o,
    output logic reg_wr_o,
    output logic reg_rd_o,
    // Read answer from the sensor.
    input wire logic [7:0] rd_data_i,
    input wire logic rd_valid_i
);
    // Idle port at time zero, so no strobe is seen during reset.
    initial
    begin
        reg_addr_o = 8'h00;
        reg_wdata_o = 8'h00;
        reg_wr_o = 1'b0;
        reg_rd_o = 1'b0;
    end

    // One write strobe; released lines carry inverted values so stale data never helps.
    task automatic wr_byte(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_i);
        reg_addr_o = a;
        reg_wdata_o = d;
        reg_wr_o = 1'b1;
        @(negedge clk_i);
        reg_wr_o = 1'b0;
        reg_addr_o = ~a;
        reg_wdata_o = ~d;
    endtask : wr_byte

    // One read strobe; the answer is taken while its one-cycle valid stands.
    task automatic rd_byte(input logic [7:0] a, output logic [7:0] d, output logic v);
        @(negedge clk_i);
        reg_addr_o = a;
        reg_rd_o = 1'b1;
        @(negedge clk_i);
        reg_rd_o = 1'b0;
        d = rd_data_i;
        v = rd_valid_i;
        reg_addr_o = ~a;
    endtask : rd_byte
endmodule : tsense_host_model

// *** triple_temp_sensor_register_map_tb.sv ***
// Self-checking bench for the sensor register map against a reference model.
// Assumes the host model drives the byte port and this bench the converter side.
`timescale 1ns/1ps
`include "tsense_defs.svh"
module triple_temp_sensor_register_map_tb;
    import tsense_pkg::*;
    localparam logic [7:0] MK = 8'h3c; // Arbitrary identification value.
    localparam logic [7:0] RV = 8'hc3; // Arbitrary identification value.
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [7:0] reg_addr_i, reg_wdata_i, rd_data_o;
    logic reg_wr_i, reg_rd_i, rd_valid_o, conv_start_o;
    logic adc_done_i = 1'b0;
    logic [1:0] adc_zone_i = 2'h0;
    logic [11:0] adc_raw_i = 12'h000;
    logic adc_fault_i = 1'b0;
    logic [2:0] conv_rate_o;
    int n_errors = 0;
    int checks_done = 0;
    int cycles = 0;
    // Reference state: latest and frozen words of the five pairs, config, flags.
    logic [15:0] fresh_m [5];
    logic [15:0] view_m [5];
    logic [7:0] cfg_m = 8'h47;
    logic busy_m = 1'b0; // Default configuration selects standby.
    logic [7:0] c_addr;
    logic f1_m = 1'b0;
    logic f2_m = 1'b0;
    logic [7:0] hi_a [5] = '{8'h00, 8'h01, 8'hf8, 8'hfa, 8'hfc};
    logic [7:0] lo_a [5] = '{8'h23, 8'h10, 8'hf9, 8'hfb, 8'hfd};
    logic [7:0] map_q [$] = '{8'h00, 8'h23, 8'h01, 8'h10, 8'hf8, 8'hf9, 8'hfa, 8'hfb,
        8'hfc, 8'hfd, 8'h02, 8'h03, 8'hfe, 8'hff};
    logic [7:0] odd_q [$] = '{8'h11, 8'h16, 8'h4a, 8'h60, 8'h61, 8'h62, 8'h79, 8'h7a,
        8'h09, 8'h0f};
    logic [11:0] bnd [11] = '{12'h800, 12'he00, 12'he01, 12'hfff, 12'h000, 12'h001,
        12'h3ff, 12'h400, 12'h5ff, 12'h600, 12'h7ff};

    // Design under test with its host partner.
    tsense_regmap #(.MAKER_CODE(MK), .REV_CODE(RV)) dut (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
        .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .rd_data_o(rd_data_o),
        .rd_valid_o(rd_valid_o), .adc_done_i(adc_done_i), .adc_zone_i(adc_zone_i),
        .adc_raw_i(adc_raw_i), .adc_fault_i(adc_fault_i), .conv_start_o(conv_start_o),
        .conv_rate_o(conv_rate_o));
    tsense_host_model host (
        .clk_i(clk_i), .reg_addr_o(reg_addr_i), .reg_wdata_o(reg_wdata_i),
        .reg_wr_o(reg_wr_i), .reg_rd_o(reg_rd_i), .rd_data_i(rd_data_o),
        .rd_valid_i(rd_valid_o));

    // Clock at 200 MHz.
    initial
    begin
        forever #2.5 clk_i = ~clk_i;
    end

    // Cuts a hang short after far more cycles than the sequence needs.
    always @(posedge clk_i)
    begin
        cycles <= cycles + 1;
        if (cycles == 8000)
        begin
            n_errors = n_errors + 1;
            end_sim();
        end
    end

    // Prints the verdict and stops the run.
    task automatic end_sim();
        if (n_errors == 0 && checks_done > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : end_sim

    // Compares one register byte.
    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        checks_done = checks_done + 1;
        if (got !== exp)
        begin
            n_errors = n_errors + 1;
            $display("[ERR] %0t byte got %h expected %h", $time, got, exp);
        end
    endtask : chk_byte

    // Compares a narrow pin output.
    task automatic chk_pin(input logic [3:0] got, input logic [3:0] exp);
        checks_done = checks_done + 1;
        if (got !== exp)
        begin
            n_errors = n_errors + 1;
            $display("[ERR] %0t pin got %h expected %h", $time, got, exp);
        end
    endtask : chk_pin

    // Formats a raw count of eighths into a stored word.
    function automatic logic [15:0] fmt(input int raw, input logic ext, input logic flt);
        int v;
        int top;
        if (flt)
            return 16'h8000;
        top = ext ? 1535 : 1023;
        v = (raw < -511) ? -511 : raw;
        v = (v > top) ? top : v;
        if (ext)
            v = v - 512;
        return {v[10:0], 5'h00};
    endfunction : fmt

    // Reads one address and compares with the model, freezing pairs on high reads.
    task automatic rd_reg(input logic [7:0] a);
        logic [7:0] exp;
        logic [7:0] d;
        logic v;
        exp = 8'h00;
        for (int p = 0; p < 5; p++)
        begin
            if (a == hi_a[p])
            begin
                view_m[p] = fresh_m[p];
                exp = view_m[p][15:8];
            end
            if (a == lo_a[p])
                exp = view_m[p][7:0];
        end
        if (a == 8'h02)
            exp = {busy_m, 5'h00, f2_m, f1_m};
        if (a == 8'h03)
            exp = cfg_m;
        if (a == 8'hfe)
            exp = MK;
        if (a == 8'hff)
            exp = RV;
        host.rd_byte(a, d, v);
        chk_pin({3'h0, v}, 4'h1);
        chk_byte(d, exp);
    endtask : rd_reg

    // Writes one address and updates the model.
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        host.wr_byte(a, d);
        if (a == 8'h09)
            cfg_m = d & 8'h47;
        if (a == 8'h09 && !d[6])
            busy_m = 1'b1;
        if (a == 8'h0f && cfg_m[6] && !busy_m)
            busy_m = 1'b1;
    endtask : wr_reg

    // One zone result from the converter; both formats update together.
    task automatic convert(input logic [1:0] z, input logic [11:0] raw, input logic flt);
        int r;
        r = $signed(raw);
        @(negedge clk_i);
        adc_done_i = 1'b1;
        adc_zone_i = z;
        adc_raw_i = raw;
        adc_fault_i = flt;
        @(negedge clk_i);
        adc_done_i = 1'b0;
        adc_raw_i = ~raw;
        adc_fault_i = ~flt;
        if (z == 2'd0)
            fresh_m[0] = fmt(r, 1'b0, 1'b0);
        if (z == 2'd1)
        begin
            fresh_m[1] = fmt(r, 1'b0, flt);
            fresh_m[3] = fmt(r, 1'b1, flt);
            f1_m = flt;
        end
        if (z == 2'd2)
        begin
            fresh_m[2] = fmt(r, 1'b0, flt);
            fresh_m[4] = fmt(r, 1'b1, flt);
            f2_m = flt;
            busy_m = 1'b0;
        end
    endtask : convert

    // One standby cycle: set rate, fire one shot, convert, read back, test the interlock.
    task automatic round(input logic [11:0] r0, input logic [11:0] r1, input logic [11:0] r2,
        input logic f1, input logic f2, input logic [2:0] rate);
        logic [7:0] c;
        c = 8'($urandom);
        c[6] = 1'b1;
        c[2:0] = rate;
        wr_reg(8'h09, c);
        chk_pin({1'b0, conv_rate_o}, {1'b0, rate});
        rd_reg(8'h03);
        wr_reg(8'h0f, 8'($urandom));
        rd_reg(8'h02);
        convert(2'd0, r0, f1);
        convert(2'd1, r1, f1);
        convert(2'd2, r2, f2);
        rd_reg(8'h02);
        for (int p = 0; p < 5; p++)
        begin
            rd_reg(hi_a[p]);
            rd_reg(lo_a[p]);
        end
        rd_reg(hi_a[3]);
        convert(2'd1, 12'($urandom), 1'b0);
        rd_reg(lo_a[3]);
        rd_reg(lo_a[1]);
        rd_reg(hi_a[3]);
    endtask : round

    // Main sequence.
    initial
    begin
        for (int p = 0; p < 5; p++)
        begin
            fresh_m[p] = 16'h0000;
            view_m[p] = 16'h0000;
        end
        void'($urandom(32'h15b98c7b));
        repeat (3) @(negedge clk_i);
        chk_pin({3'h0, conv_start_o}, 4'h0);
        chk_pin({1'b0, conv_rate_o}, 4'h7);
        rst_n_i = 1'b1;
        foreach (map_q[i])
            rd_reg(map_q[i]);
        wr_reg(8'h09, 8'h47);
        convert(2'd0, 12'($urandom), 1'b0);
        convert(2'd1, 12'($urandom), 1'b0);
        convert(2'd2, 12'($urandom), 1'b1);
        rd_reg(lo_a[4]);
        foreach (odd_q[i])
        begin
            wr_reg(odd_q[i] == 8'h09 ? 8'h11 : odd_q[i], 8'($urandom));
            rd_reg(odd_q[i]);
        end
        for (int i = 0; i < 12; i++)
        begin
            c_addr = 8'($urandom);
            if (c_addr == 8'h09 || c_addr == 8'h0f)
                c_addr = 8'h5a;
            wr_reg(c_addr, 8'($urandom));
            rd_reg(c_addr);
        end
        foreach (map_q[i])
            rd_reg(map_q[i]);
        for (int i = 0; i < 11; i++)
            round(bnd[i], bnd[i], bnd[(i + 5) % 11], 1'b0, 1'b0, 3'(i));
        for (int i = 0; i < 16; i++)
            round(12'($urandom), 12'($urandom), 12'($urandom), ($urandom % 4) == 0,
                ($urandom % 4) == 0, 3'(i));
        wr_reg(8'h09, 8'h07);
        chk_pin({3'h0, conv_start_o}, 4'h1);
        rd_reg(8'h02);
        end_sim();
    end
endmodule : triple_temp_sensor_register_map_tb
